// >>> cbm_core.sv
// Block-move engine, opcode decoder and flag helpers behind a Wishbone slave
//
// The Wishbone register port and the placing of the registers were left to the implementer.
module cbm_core
	import cbm_pkg::*;
(
	input  wire logic        i_clk,          // System clock, 200 MHz
	input  wire logic        i_rstn,         // Asynchronous reset, active low
	input  wire logic        i_ce,           // Clock enable, freezes state when low
	input  wire logic        i_wb_cyc,       // Wishbone cycle
	input  wire logic        i_wb_stb,       // Wishbone strobe
	input  wire logic        i_wb_we,        // Wishbone write enable
	input  wire logic [7:0]  i_wb_adr,       // Wishbone byte address
	input  wire logic [31:0] i_wb_dat,       // Wishbone write data
	input  wire logic [3:0]  i_wb_sel,       // Wishbone byte lanes
	output logic      [31:0] o_wb_dat,       // Wishbone read data
	output logic             o_wb_ack,       // Wishbone acknowledge
	output logic             o_mem_rd_req,   // Memory read request, held to ack
	output logic      [31:0] o_mem_rd_adr,   // Memory read address
	input  wire logic        i_mem_rd_ack,   // Memory read answer
	input  wire logic [7:0]  i_mem_rd_dat,   // Memory read byte
	output logic             o_mem_wr_req,   // Memory write request, held to ack
	output logic      [31:0] o_mem_wr_adr,   // Memory write address
	output logic      [7:0]  o_mem_wr_dat,   // Memory write byte
	input  wire logic        i_mem_wr_ack,   // Memory write answer
	output logic             o_busy          // Block move in progress
);

	logic               rst_meta_q;
	logic               rst_n_q;
	logic               ack_q;
	logic [31:0]        rdat_q;
	logic [31:0]        rdat_d;
	logic [31:0]        ctrl_q;
	logic [15:0]        count_q;
	logic [31:0]        src_q;
	logic [31:0]        dst_q;
	logic [31:0]        opcode_q;
	logic [15:0]        opa_q;
	logic [15:0]        opb_q;
	logic [17:0]        states_q;
	logic [15:0]        rd_left_q;
	logic               word_q;
	logic               rd_req_q;
	logic               wr_req_q;
	logic [7:0]         wr_dat_q;
	cbm_move_state_type mv_q;
	logic               req;
	logic               wr;
	logic [5:0]         widx;
	logic               idle;
	logic               start;
	logic [15:0]        n_init;
	logic [15:0]        mv_cnt;
	logic               rd_go;
	logic               wr_done;
	logic               last_wr;
	logic               word_sel;
	cbm_class_type      cls;
	logic [3:0]         len;
	logic [3:0]         rs_f;
	logic [3:0]         rd_f;
	logic [2:0]         inc;
	logic [7:0]         b1;
	logic [7:0]         b2;
	logic [2:0]         nsave;
	logic               extra;
	logic [3:0]         save_states;
	logic [12:0]        half_sum;
	logic               half_carry;
	logic               half_borrow;
	logic [7:0]         x_sum;
	logic [7:0]         x_diff;
	logic               z_addx;
	logic               z_subx;
	logic [15:0]        dvd_abs;
	logic [15:0]        dvs_ext;
	logic [15:0]        dvs_abs;
	logic               dvs_neg;
	logic               dvs_zero;
	logic               quo_neg;
	logic [31:0]        flags;

	cbm_stream_if fin ();
	cbm_stream_if fout ();

	// Merge a bus write into a register, lane by lane
	function automatic logic [31:0] lanes(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] sel);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (sel[i]) begin
				r[8*i +: 8] = nw[8*i +: 8];
			end
		end
		return r;
	endfunction

	// Reset release passes two flops so no flop leaves reset on a ragged edge
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			rst_meta_q <= 1'b0;
			rst_n_q    <= 1'b0;
		end else if (i_ce) begin
			rst_meta_q <= 1'b1;
			rst_n_q    <= rst_meta_q;
		end
	end

	// Bus request decode; ack follows one cycle after the request
	assign req   = i_wb_cyc & i_wb_stb & ~ack_q;
	assign wr    = req & i_wb_we;
	assign widx  = i_wb_adr[7:2];
	assign idle  = (mv_q == MV_IDLE);
	assign start = wr & (widx == REG_CTRL[7:2]) & i_wb_sel[0] & i_wb_dat[CTRL_START] & idle;

	always_ff @(posedge i_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			ack_q  <= 1'b0;
			rdat_q <= 32'h0000_0000;
		end else if (i_ce) begin
			ack_q  <= req;
			rdat_q <= req ? rdat_d : 32'h0000_0000;
		end
	end

	assign o_wb_ack = ack_q;
	assign o_wb_dat = rdat_q;

	// Software registers; pointer and count are locked while a move runs
	always_ff @(posedge i_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			ctrl_q   <= CTRL_RESET;
			src_q    <= 32'h0000_0000;
			dst_q    <= 32'h0000_0000;
			opcode_q <= 32'h0000_0000;
			opa_q    <= 16'h0000;
			opb_q    <= 16'h0000;
		end else if (i_ce) begin
			if (wr && widx == REG_CTRL[7:2]) begin
				ctrl_q <= lanes(ctrl_q, i_wb_dat, i_wb_sel) & CTRL_MASK;
			end
			if (wr && widx == REG_OPCODE[7:2]) begin
				opcode_q <= lanes(opcode_q, i_wb_dat, i_wb_sel);
			end
			if (wr && widx == REG_OPA[7:2]) begin
				opa_q <= 16'(lanes({16'h0000, opa_q}, i_wb_dat, i_wb_sel));
			end
			if (wr && widx == REG_OPB[7:2]) begin
				opb_q <= 16'(lanes({16'h0000, opb_q}, i_wb_dat, i_wb_sel));
			end
			if (wr && idle && widx == REG_SRC[7:2]) begin
				src_q <= lanes(src_q, i_wb_dat, i_wb_sel);
			end else if (rd_req_q && i_mem_rd_ack) begin
				src_q <= src_q + 32'h0000_0001;
			end
			if (wr && idle && widx == REG_DST[7:2]) begin
				dst_q <= lanes(dst_q, i_wb_dat, i_wb_sel);
			end else if (wr_done) begin
				dst_q <= dst_q + 32'h0000_0001;
			end
		end
	end

	// Transfer size: the form bit comes from the starting write itself, not the stale register
	assign word_sel = i_wb_sel[0] ? i_wb_dat[CTRL_WORD] : ctrl_q[CTRL_WORD];
	assign n_init  = word_sel ? count_q : {8'h00, count_q[7:0]};
	assign mv_cnt  = word_q ? count_q : {8'h00, count_q[7:0]};
	assign wr_done = wr_req_q & i_mem_wr_ack;
	assign last_wr = wr_done & (mv_cnt == 16'h0001);

	// Count register; byte form leaves the high byte untouched
	always_ff @(posedge i_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			count_q <= 16'h0000;
		end else if (i_ce) begin
			if (wr && idle && widx == REG_COUNT[7:2]) begin
				count_q <= 16'(lanes({16'h0000, count_q}, i_wb_dat, i_wb_sel));
			end else if (wr_done && word_q) begin
				count_q <= count_q - 16'h0001;
			end else if (wr_done) begin
				count_q[7:0] <= count_q[7:0] - 8'h01;
			end
		end
	end

	// Move sequencer; a zero count ends at once, with only the base states charged
	always_ff @(posedge i_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			mv_q     <= MV_IDLE;
			word_q   <= 1'b0;
			states_q <= 18'h00000;
		end else if (i_ce) begin
			unique case (mv_q)
				MV_IDLE: begin
					if (start) begin
						word_q   <= word_sel;
						// Figures assume on-chip code and operands; memory stalls are not charged
						states_q <= MOVE_BASE_STATES + MOVE_BYTE_STATES * {2'b00, n_init};
						if (n_init != 16'h0000) begin
							mv_q <= MV_RUN;
						end
					end
				end
				MV_RUN: begin
					if (last_wr) begin
						mv_q <= MV_IDLE;
					end
				end
			endcase
		end
	end

	// Read side runs ahead into the buffer and stalls when it is full
	assign rd_go = (mv_q == MV_RUN) & (rd_left_q != 16'h0000) & ~rd_req_q & fin.ready;

	always_ff @(posedge i_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			rd_left_q <= 16'h0000;
			rd_req_q  <= 1'b0;
		end else if (i_ce) begin
			if (start) begin
				rd_left_q <= n_init;
			end else if (rd_go) begin
				rd_left_q <= rd_left_q - 16'h0001;
			end
			if (rd_go) begin
				rd_req_q <= 1'b1;
			end else if (i_mem_rd_ack) begin
				rd_req_q <= 1'b0;
			end
		end
	end

	// Ready was high when the read issued and only pops happen meanwhile
	assign fin.valid = rd_req_q & i_mem_rd_ack;
	assign fin.data  = i_mem_rd_dat;

	cbm_fifo #(
		.WIDTH (FIFO_W),
		.DEPTH (FIFO_D)
	) u_fifo (
		.i_clk  (i_clk),
		.i_rstn (rst_n_q),
		.i_ce   (i_ce),
		.s_in   (fin),
		.s_out  (fout)
	);

	// Write side takes one byte at a time; a slow write ack backs up the buffer
	assign fout.ready = (mv_q == MV_RUN) & ~wr_req_q;

	always_ff @(posedge i_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			wr_req_q <= 1'b0;
			wr_dat_q <= 8'h00;
		end else if (i_ce) begin
			if (fout.valid && fout.ready) begin
				wr_req_q <= 1'b1;
				wr_dat_q <= fout.data;
			end else if (i_mem_wr_ack) begin
				wr_req_q <= 1'b0;
			end
		end
	end

	assign o_mem_rd_req = rd_req_q;
	assign o_mem_rd_adr = src_q;
	assign o_mem_wr_req = wr_req_q;
	assign o_mem_wr_adr = dst_q;
	assign o_mem_wr_dat = wr_dat_q;
	assign o_busy       = ~idle;

	// Decoder looks at the first two bytes only, so length is ready before extensions
	assign b1 = opcode_q[31:24];
	assign b2 = opcode_q[23:16];

	always_comb begin
		cls  = CLS_NONE;
		len  = 4'h0;
		rs_f = b2[7:4];
		rd_f = b2[3:0];
		inc  = 3'h0;
		case (b1)
			OP_ADD_B_RR: begin
				cls = CLS_ADD_B_RR;
				len = LEN_2;
			end
			OP_ADD_L_RR: begin
				if (b2[7] && !b2[3]) begin
					cls  = CLS_ADD_L_RR;
					len  = LEN_2;
					rs_f = {1'b0, b2[6:4]};
				end
			end
			OP_ADD_SMALL_TO_ADDRESS_REG: begin
				if (!b2[3]) begin
					len = LEN_2;
					cls = CLS_ADD_SMALL_TO_ADDRESS_REG;
					case (b2[7:4])
						ADD_SMALL_TO_ADDRESS_REG_BY1: inc = 3'h1;
						ADD_SMALL_TO_ADDRESS_REG_BY2: inc = 3'h2;
						ADD_SMALL_TO_ADDRESS_REG_BY4: inc = 3'h4;
						default: begin
							cls = CLS_NONE;
							len = 4'h0;
						end
					endcase
				end
			end
			OP_IMM_L: begin
				if (!b2[3] && b2[7:4] == SUB_ADD_IMM) begin
					cls = CLS_ADD_L_IMM;
					len = LEN_6;
				end else if (!b2[3] && b2[7:4] == SUB_AND_IMM) begin
					cls = CLS_AND_L_IMM;
					len = LEN_6;
				end
			end
			OP_BRA8: begin
				cls = CLS_BRA8;
				len = LEN_2;
			end
			OP_BRA16: begin
				if (b2 == OP_BRA16_2) begin
					cls = CLS_BRA16;
					len = LEN_4;
				end
			end
			default: begin
				cls = CLS_NONE;
			end
		endcase
	end

	// Save or restore timing: two states per register plus three, one more with EXR and ANNOT both set, for two to four registers only; other counts give zero
	assign nsave       = ctrl_q[CTRL_NSAVE +: 3];
	assign extra       = ctrl_q[CTRL_EXR] & ctrl_q[CTRL_ANNOT];
	assign save_states = (nsave >= SAVE_MIN_REGS && nsave <= SAVE_MAX_REGS) ?
		SAVE_BASE_STATES + SAVE_REG_STATES * {1'b0, nsave} + {3'h0, extra} : 4'h0;

	// Word half-carry and half-borrow look only at the low twelve bits
	assign half_sum    = {1'b0, opa_q[HALF_BIT:0]} + {1'b0, opb_q[HALF_BIT:0]};
	assign half_carry  = half_sum[HALF_BIT+1];
	assign half_borrow = (opa_q[HALF_BIT:0] < opb_q[HALF_BIT:0]);

	// Extended add and subtract can only clear zero, so multi-byte results chain
	assign x_sum  = opa_q[7:0] + opb_q[7:0];
	assign x_diff = opa_q[7:0] - opb_q[7:0];
	assign z_addx = ctrl_q[CTRL_ZIN] & (x_sum == 8'h00);
	assign z_subx = ctrl_q[CTRL_ZIN] & (x_diff == 8'h00);

	// Division by byte divisor; sign of quotient found by magnitude compare
	assign dvs_ext  = {{8{opb_q[7]}}, opb_q[7:0]};
	assign dvs_abs  = opb_q[7] ? (16'h0000 - dvs_ext) : dvs_ext;
	assign dvd_abs  = opa_q[15] ? (16'h0000 - opa_q) : opa_q;
	assign dvs_neg  = opb_q[7];
	assign dvs_zero = (opb_q[7:0] == 8'h00);
	assign quo_neg  = ~dvs_zero & (opa_q[15] ^ opb_q[7]) & (dvd_abs >= dvs_abs);

	assign flags = {26'h0, quo_neg, dvs_zero, dvs_neg, z_subx, z_addx, half_carry}
		| {25'h0, half_borrow, 6'h00};

	// Read multiplexer; unmapped words read as zero
	always_comb begin
		rdat_d = 32'h0000_0000;
		case (widx)
			REG_CTRL[7:2]:   rdat_d = ctrl_q;
			REG_COUNT[7:2]:  rdat_d = {16'h0000, count_q};
			REG_SRC[7:2]:    rdat_d = src_q;
			REG_DST[7:2]:    rdat_d = dst_q;
			REG_STATUS[7:2]: rdat_d = {states_q, 13'h0000, ~idle};
			REG_OPCODE[7:2]: rdat_d = opcode_q;
			REG_DECODE[7:2]: rdat_d = {8'h00, save_states, 1'b0, inc, rd_f, rs_f, len, cls};
			REG_OPA[7:2]:    rdat_d = {16'h0000, opa_q};
			REG_OPB[7:2]:    rdat_d = {16'h0000, opb_q};
			REG_FLAGS[7:2]:  rdat_d = flags;
			default:         rdat_d = 32'h0000_0000;
		endcase
	end

endmodule

// >>> cbm_core_asserts.sv
// Port-level checks for the block-move core
module cbm_core_asserts (
	input wire logic        i_clk,        // System clock
	input wire logic        i_rstn,       // Reset, active low
	input wire logic        i_ce,         // Clock enable
	input wire logic        i_wb_cyc,     // Bus cycle
	input wire logic        i_wb_stb,     // Bus strobe
	input wire logic        i_wb_we,      // Bus write
	input wire logic [7:0]  i_wb_adr,     // Bus address
	input wire logic [31:0] i_wb_dat,     // Bus write data
	input wire logic [3:0]  i_wb_sel,     // Bus lanes
	input wire logic [31:0] o_wb_dat,     // Bus read data
	input wire logic        o_wb_ack,     // Bus answer
	input wire logic        o_mem_rd_req, // Read request
	input wire logic [31:0] o_mem_rd_adr, // Read address
	input wire logic        i_mem_rd_ack, // Read answer
	input wire logic [7:0]  i_mem_rd_dat, // Read byte
	input wire logic        o_mem_wr_req, // Write request
	input wire logic [31:0] o_mem_wr_adr, // Write address
	input wire logic [7:0]  o_mem_wr_dat, // Write byte
	input wire logic        i_mem_wr_ack, // Write answer
	input wire logic        o_busy        // Move running
);
	timeunit 1ns;
	timeprecision 1ps;
	// All checks share one clock and one reset
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rstn);

	AST_ACK_NEXT: assert property (i_ce && i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack)
		else $error("bus request not answered in one cycle");
	AST_ACK_ONE: assert property (o_wb_ack |=> !o_wb_ack)
		else $error("bus answer longer than one cycle");
	AST_ACK_CAUSE: assert property (o_wb_ack |-> $past(i_wb_cyc && i_wb_stb))
		else $error("bus answer without request");
	AST_DAT_IDLE: assert property (!o_wb_ack |-> o_wb_dat == 32'h0)
		else $error("read data outside answer cycle");
	AST_RD_HOLD: assert property (o_mem_rd_req && !i_mem_rd_ack |=>
		o_mem_rd_req && $stable(o_mem_rd_adr))
		else $error("read request dropped or moved before answer");
	AST_RD_STEP: assert property (o_mem_rd_req && i_mem_rd_ack |=>
		!o_mem_rd_req && o_mem_rd_adr == $past(o_mem_rd_adr) + 32'h1)
		else $error("source pointer did not step by one");
	AST_WR_HOLD: assert property (o_mem_wr_req && !i_mem_wr_ack |=>
		o_mem_wr_req && $stable({o_mem_wr_adr, o_mem_wr_dat}))
		else $error("write request dropped or changed before answer");
	AST_WR_STEP: assert property (o_mem_wr_req && i_mem_wr_ack |=>
		!o_mem_wr_req && o_mem_wr_adr == $past(o_mem_wr_adr) + 32'h1)
		else $error("destination pointer did not step by one");
	AST_IDLE_QUIET: assert property (!o_busy |-> !o_mem_rd_req && !o_mem_wr_req)
		else $error("memory traffic while idle");

	// Main scenarios reached
	cover property ($fell(o_busy));
	cover property (o_mem_rd_req && !i_mem_rd_ack [*3]);
	cover property (o_mem_wr_req && !i_mem_wr_ack [*8]);
endmodule

// >>> cbm_fifo.sv
// Byte buffer between memory reads and memory writes
module cbm_fifo
	import cbm_pkg::*;
#(
	parameter int unsigned WIDTH = FIFO_W,
	parameter int unsigned DEPTH = FIFO_D
) (
	input  wire logic     i_clk,   // System clock
	input  wire logic     i_rstn,  // Synchronised reset, active low
	input  wire logic     i_ce,    // Clock enable
	cbm_stream_if.sink    s_in,    // Filling side
	cbm_stream_if.source  s_out    // Draining side
);
	localparam int unsigned AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0]    wr_q;
	logic [AW-1:0]    rd_q;
	logic [AW:0]      cnt_q;
	logic             push;
	logic             pop;

	// Full and empty come straight from the occupancy count
	assign s_in.ready  = (cnt_q != (AW+1)'(DEPTH));
	assign s_out.valid = (cnt_q != '0);
	assign s_out.data  = mem_q[rd_q];
	assign push        = s_in.valid & s_in.ready;
	assign pop         = s_out.valid & s_out.ready;

	// Storage needs no reset; empty slots are never read
	always_ff @(posedge i_clk) begin
		if (i_ce && push) begin
			mem_q[wr_q] <= s_in.data;
		end
	end

	// Pointers wrap naturally since depth is a power of two
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			wr_q  <= '0;
			rd_q  <= '0;
			cnt_q <= '0;
		end else if (i_ce) begin
			if (push) begin
				wr_q <= wr_q + AW'(1);
			end
			if (pop) begin
				rd_q <= rd_q + AW'(1);
			end
			if (push && !pop) begin
				cnt_q <= cnt_q + (AW+1)'(1);
			end else if (pop && !push) begin
				cnt_q <= cnt_q - (AW+1)'(1);
			end
		end
	end

endmodule

// >>> cbm_mem_model.sv
// Byte memory answering the core's read and write ports
module cbm_mem_model (
	input  wire logic        i_clk,    // System clock
	input  wire logic [3:0]  i_rdly,   // Wait cycles before a read answer
	input  wire logic [3:0]  i_wdly,   // Wait cycles before a write answer
	input  wire logic        i_rd_req, // Read request
	input  wire logic [31:0] i_rd_adr, // Read address
	output logic             o_rd_ack, // Read answer
	output logic      [7:0]  o_rd_dat, // Read byte
	input  wire logic        i_wr_req, // Write request
	input  wire logic [31:0] i_wr_adr, // Write address
	input  wire logic [7:0]  i_wr_dat, // Write byte
	output logic             o_wr_ack  // Write answer
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] mem [1024];
	logic [3:0] rwait;
	logic [3:0] wwait;

	// Known pattern so that every copied byte can be traced
	initial begin
		for (int i = 0; i < 1024; i++) mem[i] = 8'(i) ^ 8'ha5;
		{o_rd_ack, o_wr_ack, rwait, wwait, o_rd_dat} = '0;
	end

	// Read side; the data lines churn when neither a request nor an answer stands
	always @(posedge i_clk) begin
		o_rd_ack <= 1'b0;
		if (i_rd_req && !o_rd_ack && rwait >= i_rdly) begin
			o_rd_ack <= 1'b1;
			o_rd_dat <= mem[i_rd_adr[9:0]];
			rwait    <= 4'h0;
		end else if (i_rd_req && !o_rd_ack) begin
			rwait <= rwait + 4'h1;
		end else if (!o_rd_ack) begin
			o_rd_dat <= ~o_rd_dat;
		end
	end

	// Write side; a long wait here fills the core's buffer
	always @(posedge i_clk) begin
		o_wr_ack <= 1'b0;
		if (i_wr_req && !o_wr_ack && wwait >= i_wdly) begin
			o_wr_ack                <= 1'b1;
			mem[i_wr_adr[9:0]]      <= i_wr_dat;
			wwait                   <= 4'h0;
		end else if (i_wr_req && !o_wr_ack) begin
			wwait <= wwait + 4'h1;
		end
	end
endmodule

// >>> cbm_pkg.sv
// Constants and types shared by the block-move and opcode-decode core
package cbm_pkg;

	// Register byte offsets on the bus
	localparam logic [7:0]  REG_CTRL    = 8'h00;
	localparam logic [7:0]  REG_COUNT   = 8'h04;
	localparam logic [7:0]  REG_SRC     = 8'h08;
	localparam logic [7:0]  REG_DST     = 8'h0c;
	localparam logic [7:0]  REG_STATUS  = 8'h10;
	localparam logic [7:0]  REG_OPCODE  = 8'h14;
	localparam logic [7:0]  REG_DECODE  = 8'h18;
	localparam logic [7:0]  REG_OPA     = 8'h1c;
	localparam logic [7:0]  REG_OPB     = 8'h20;
	localparam logic [7:0]  REG_FLAGS   = 8'h24;

	// Control and status fields, control reset value and mask
	localparam int unsigned CTRL_START  = 0;
	localparam int unsigned CTRL_WORD   = 1;
	localparam int unsigned CTRL_EXR    = 2;
	localparam int unsigned CTRL_ZIN    = 3;
	localparam int unsigned CTRL_ANNOT  = 4;
	localparam int unsigned CTRL_NSAVE  = 8;
	localparam logic [31:0] CTRL_RESET  = 32'h0000_0000;
	localparam logic [31:0] CTRL_MASK   = 32'h0000_071e;
	localparam int unsigned STAT_BUSY   = 0;
	localparam int unsigned STAT_STATES = 14;

	// Opcode bytes and nibbles
	localparam logic [7:0]  OP_ADD_B_RR = 8'h08;
	localparam logic [7:0]  OP_ADD_L_RR = 8'h0a;
	localparam logic [7:0]  OP_ADD_SMALL_TO_ADDRESS_REG     = 8'h0b;
	localparam logic [7:0]  OP_IMM_L    = 8'h7a;
	localparam logic [7:0]  OP_BRA8     = 8'h40;
	localparam logic [7:0]  OP_BRA16    = 8'h58;
	localparam logic [7:0]  OP_BRA16_2  = 8'h00;
	localparam logic [3:0]  SUB_ADD_IMM = 4'h1;
	localparam logic [3:0]  SUB_AND_IMM = 4'h6;
	localparam logic [3:0]  ADD_SMALL_TO_ADDRESS_REG_BY1    = 4'h0;
	localparam logic [3:0]  ADD_SMALL_TO_ADDRESS_REG_BY2    = 4'h8;
	localparam logic [3:0]  ADD_SMALL_TO_ADDRESS_REG_BY4    = 4'h9;
	localparam logic [3:0]  LEN_2       = 4'h2;
	localparam logic [3:0]  LEN_4       = 4'h4;
	localparam logic [3:0]  LEN_6       = 4'h6;

	// State accounting and half-carry bit position
	localparam logic [17:0] MOVE_BASE_STATES = 18'h00004;
	localparam logic [17:0] MOVE_BYTE_STATES = 18'h00002;
	localparam logic [3:0]  SAVE_BASE_STATES = 4'h3;
	localparam logic [3:0]  SAVE_REG_STATES  = 4'h2;
	localparam logic [2:0]  SAVE_MIN_REGS    = 3'h2;
	localparam logic [2:0]  SAVE_MAX_REGS    = 3'h4;
	localparam int unsigned HALF_BIT         = 11;

	// Buffer shape
	localparam int unsigned FIFO_W = 8;
	localparam int unsigned FIFO_D = 16;

	typedef enum logic [3:0] {
		CLS_NONE      = 4'b0000,
		CLS_ADD_B_RR  = 4'b0001,
		CLS_ADD_L_RR  = 4'b0010,
		CLS_ADD_L_IMM = 4'b0011,
		CLS_AND_L_IMM = 4'b0100,
		CLS_ADD_SMALL_TO_ADDRESS_REG      = 4'b0101,
		CLS_BRA8      = 4'b0110,
		CLS_BRA16     = 4'b0111
	} cbm_class_type;

	typedef enum logic [0:0] {
		MV_IDLE = 1'b0,
		MV_RUN  = 1'b1
	} cbm_move_state_type;

endpackage

// >>> cbm_stream_if.sv
// Valid/ready byte stream between the move engine and its buffer
interface cbm_stream_if;
	import cbm_pkg::*;
	logic              valid;
	logic              ready;
	logic [FIFO_W-1:0] data;
	modport source (output valid, output data, input ready);
	modport sink   (input valid, input data, output ready);
endinterface

// >>> tb_top.sv
// Self-checking bench for the block-move and decode core
`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin mismatches++; \
	$display("CHECK FAILED %s expected %h seen %h", nm, ex, got); end end
module tb_top import cbm_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	logic        i_clk  = 1'b0;
	logic        i_rstn = 1'b0;
	logic        cyc    = 1'b0;
	logic        stb    = 1'b0;
	logic        we     = 1'b0;
	logic [7:0]  adr    = 8'h00;
	logic [31:0] wdat   = 32'h0;
	logic [3:0]  rdly   = 4'h0;
	logic [3:0]  wdly   = 4'h0;
	logic [31:0] rdat, rd_adr, wr_adr, rv;
	logic [7:0]  rd_dat, wr_dat;
	logic        ack, rd_req, rd_ack, wr_req, wr_ack, busy;
	int          mismatches = 0;
	int          compares   = 0;
	localparam logic [15:0] DOP [10] = '{16'h0812, 16'h0a92, 16'h7a13, 16'h7a63, 16'h0b05,
		16'h0b85, 16'h0b95, 16'h4010, 16'h5800, 16'h5810};
	localparam logic [31:0] DEX [10] = '{32'h2121, 32'h22, 32'h63, 32'h64, 32'h10025,
		32'h20025, 32'h40025, 32'h26, 32'h47, 32'h0};
	localparam logic [31:0] DMK [10] = '{32'hffff, 32'hff, 32'hff, 32'hff, 32'h700ff,
		32'h700ff, 32'h700ff, 32'hff, 32'hff, 32'hf};
	localparam logic [15:0] FA [8] = '{16'h0800, 16'h1, 16'h10, 16'h10, 16'h10, 16'h0, 16'h1, 16'h0};
	localparam logic [15:0] FB [8] = '{16'h0800, 16'h2, 16'hff, 16'h1, 16'h0, 16'h0, 16'h0, 16'h0};
	localparam logic [7:0]  FC [8] = '{8'h0, 8'h0, 8'h0, 8'h0, 8'h0, 8'h8, 8'h8, 8'h0};
	localparam logic [7:0]  FM [8] = '{8'h01, 8'h41, 8'h38, 8'h38, 8'h10, 8'h06, 8'h06, 8'h06};
	localparam logic [7:0]  FE [8] = '{8'h01, 8'h40, 8'h28, 8'h00, 8'h10, 8'h06, 8'h00, 8'h00};

	// 200 MHz clock
	always #2.5 i_clk = ~i_clk;

	cbm_core dut (.i_clk(i_clk), .i_rstn(i_rstn), .i_ce(1'b1), .i_wb_cyc(cyc), .i_wb_stb(stb),
		.i_wb_we(we), .i_wb_adr(adr), .i_wb_dat(wdat), .i_wb_sel(4'hf), .o_wb_dat(rdat),
		.o_wb_ack(ack), .o_mem_rd_req(rd_req), .o_mem_rd_adr(rd_adr), .i_mem_rd_ack(rd_ack),
		.i_mem_rd_dat(rd_dat), .o_mem_wr_req(wr_req), .o_mem_wr_adr(wr_adr),
		.o_mem_wr_dat(wr_dat), .i_mem_wr_ack(wr_ack), .o_busy(busy));
	cbm_mem_model u_mem (.i_clk(i_clk), .i_rdly(rdly), .i_wdly(wdly), .i_rd_req(rd_req),
		.i_rd_adr(rd_adr), .o_rd_ack(rd_ack), .o_rd_dat(rd_dat), .i_wr_req(wr_req),
		.i_wr_adr(wr_adr), .i_wr_dat(wr_dat), .o_wr_ack(wr_ack));

	// Verdict and end of run
	task automatic end_of_test();
		if (mismatches == 0 && compares > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	function automatic logic [7:0] pat(input logic [31:0] a);
		return a[7:0] ^ 8'ha5;
	endfunction

	// One classic cycle, held until the answer is sampled
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge i_clk);
		{cyc, stb, we, adr, wdat} <= {2'b11, w, a, d};
		do begin
			@(posedge i_clk);
			n++;
		end while (ack !== 1'b1 && n < 100);
		rv = rdat;
		if (n >= 100) begin
			mismatches++;
			end_of_test();
		end
		{cyc, stb, we} <= 3'b000;
	endtask

	// Start a move, wait it out, then check copy, pointers, count and states
	task automatic move(input logic [31:0] c, input logic [15:0] cnt, input logic [31:0] s,
		input logic [31:0] d, input logic [3:0] rw, input logic [3:0] ww);
		int n;
		int k;
		n = c[CTRL_WORD] ? int'(cnt) : int'(cnt[7:0]);
		k = 0;
		{rdly, wdly} <= {rw, ww};
		xfer(1'b1, REG_COUNT, {16'h0, cnt});
		xfer(1'b1, REG_SRC, s);
		xfer(1'b1, REG_DST, d);
		xfer(1'b1, REG_CTRL, c | 32'h1);
		while (busy !== 1'b0 && k < 5000) begin
			@(posedge i_clk);
			k++;
		end
		if (k >= 5000) begin
			mismatches++;
			end_of_test();
		end
		xfer(1'b0, REG_STATUS, 32'h0);
		`CHK("states", 18'(4 + 2 * n), rv[31:14])
		xfer(1'b0, REG_SRC, 32'h0);
		`CHK("source", s + 32'(n), rv)
		xfer(1'b0, REG_DST, 32'h0);
		`CHK("dest", d + 32'(n), rv)
		xfer(1'b0, REG_COUNT, 32'h0);
		`CHK("count", c[CTRL_WORD] ? 32'h0 : {16'h0, cnt[15:8], 8'h0}, rv)
		for (int i = 0; i <= n; i++) begin
			`CHK("byte", pat(i < n ? s + 32'(i) : d + 32'(i)), u_mem.mem[10'(d + 32'(i))])
		end
	endtask

	// Main sequence
	initial begin
		repeat (8) @(posedge i_clk);
		i_rstn <= 1'b1;
		repeat (3) @(posedge i_clk);
		xfer(1'b0, REG_CTRL, 32'h0);
		`CHK("ctrl reset", CTRL_RESET, rv)
		move(32'h0, 16'h0103, 32'h010, 32'h200, 4'h0, 4'h0);
		move(32'h2, 16'h0112, 32'h040, 32'h300, 4'h3, 4'h9);
		move(32'h2, 16'h0000, 32'h080, 32'h180, 4'h2, 4'h2);
		move(32'h0, 16'h0500, 32'h0a0, 32'h1a0, 4'h1, 4'h1);
		for (int i = 0; i < 10; i++) begin
			xfer(1'b1, REG_OPCODE, {DOP[i], 16'h0});
			xfer(1'b0, REG_DECODE, 32'h0);
			`CHK("decode", DEX[i], rv & DMK[i])
		end
		for (int r = 1; r < 6; r++) begin
			for (int e = 0; e < 2; e++) begin
				xfer(1'b1, REG_CTRL, (32'(r) << 8) | (e ? 32'h14 : 32'h0));
				xfer(1'b0, REG_DECODE, 32'h0);
				`CHK("save", (r > 1 && r < 5) ? 4'(3 + 2 * r + e) : 4'h0, rv[23:20])
			end
		end
		for (int i = 0; i < 8; i++) begin
			xfer(1'b1, REG_OPA, {16'h0, FA[i]});
			xfer(1'b1, REG_OPB, {16'h0, FB[i]});
			xfer(1'b1, REG_CTRL, {24'h0, FC[i]});
			xfer(1'b0, REG_FLAGS, 32'h0);
			`CHK("flags", FE[i], rv[7:0] & FM[i])
		end
		xfer(1'b0, 8'h3c, 32'h0);
		`CHK("unmapped", 32'h0, rv)
		end_of_test();
	end

	// Cuts a hang short; the sequence needs a few thousand cycles
	initial begin
		repeat (40000) @(posedge i_clk);
		mismatches++;
		end_of_test();
	end
endmodule

bind cbm_core cbm_core_asserts u_chk (.i_clk(i_clk), .i_rstn(i_rstn), .i_ce(i_ce),
	.i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr),
	.i_wb_dat(i_wb_dat), .i_wb_sel(i_wb_sel), .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack),
	.o_mem_rd_req(o_mem_rd_req), .o_mem_rd_adr(o_mem_rd_adr), .i_mem_rd_ack(i_mem_rd_ack),
	.i_mem_rd_dat(i_mem_rd_dat), .o_mem_wr_req(o_mem_wr_req), .o_mem_wr_adr(o_mem_wr_adr),
	.o_mem_wr_dat(o_mem_wr_dat), .i_mem_wr_ack(i_mem_wr_ack), .o_busy(o_busy));
